//--- design/pmr_regs.sv
// ---------------------------------------------------------------
// ---------------------------------------------------------------
//
// The Avalon-MM interface to the registers is this design's own decision.
`default_nettype none
module pmr_regs #(
   parameter logic [15:0] ID_HIGH = 16'h1234, // arbitrary value
   parameter logic [15:0] ID_LOW  = 16'h5678  // arbitrary value
) (
   // clock, reset, enable
   input  wire logic              REF_CLK_I,
   input  wire logic              RESETN_I,
   input  wire logic              CE_I,
   // avalon-mm slave
   input  wire logic [6:0]        AVS_ADDRESS_I,
   input  wire logic              AVS_READ_I,
   input  wire logic              AVS_WRITE_I,
   input  wire logic [31:0]       AVS_WRITEDATA_I,
   input  wire logic [3:0]        AVS_BYTEENABLE_I,
   output var  logic [31:0]       AVS_READDATA_O,
   output var  logic              AVS_WAITREQUEST_O,
   // negotiation engine and mii
   input  wire pmr_pkg::pmr_an_s  AN_STAT_I,
   input  wire logic              TX_EN_I,
   output var  logic              COL_O,
   output var  pmr_pkg::pmr_ctl_s PHY_CTL_O
);

   // -----------------------------------------------------------
   // state
   // -----------------------------------------------------------
   pmr_pkg::pmr_bus_e bus_q;
   logic [31:0]       rdata_q;
   logic              wait_q;
   logic              srst_q;
   logic [3:0]        srst_cnt_q;
   logic              loop_q;
   logic              spd_q;
   logic              anen_q;
   logic              pdn_q;
   logic              dup_q;
   logic              colt_q;
   logic              anrs_q;
   logic [15:0]       ana_q;
   logic [15:0]       anp_q;
   logic [15:0]       anx_q;
   logic [15:0]       vc0_q;
   logic [15:0]       vc1_q;
   logic [15:0]       vc2_q;
   logic              col_q;
   pmr_pkg::pmr_ctl_s ctl_q;

   logic [4:0]  idx;
   logic        req;
   logic        fire_wr;
   logic        lo_en;
   logic        hi_en;
   logic [15:0] wd;
   logic        spd_rd;
   logic        dup_rd;
   logic [15:0] rd_d;

   // -----------------------------------------------------------
   // bus decode
   // -----------------------------------------------------------
   // index from byte address, low two bits ignored
   assign idx     = AVS_ADDRESS_I[6:2];
   assign req     = AVS_READ_I | AVS_WRITE_I;
   assign fire_wr = CE_I & AVS_WRITE_I & (bus_q == pmr_pkg::BUS_ACK);
   assign lo_en   = AVS_BYTEENABLE_I[0];
   assign hi_en   = AVS_BYTEENABLE_I[1];
   assign wd      = AVS_WRITEDATA_I[15:0];

   // byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [15:0] nw,
                                         input logic        le,
                                         input logic        he);
      merge = {he ? nw[15:8] : old[15:8], le ? nw[7:0] : old[7:0]};
   endfunction

   // negotiated or forced view of speed and duplex
   assign spd_rd = anen_q ? AN_STAT_I.speed_100 : spd_q;
   assign dup_rd = anen_q ? AN_STAT_I.full_duplex : dup_q;

   // -----------------------------------------------------------
   // read mux
   // -----------------------------------------------------------
   always_comb begin
      rd_d = 16'h0000;
      case (idx)
         pmr_pkg::IDX_BMC: begin
            rd_d[pmr_pkg::B_SRST] = srst_q;
            rd_d[pmr_pkg::B_LOOP] = loop_q;
            rd_d[pmr_pkg::B_SPD]  = spd_rd;
            rd_d[pmr_pkg::B_ANEN] = anen_q;
            rd_d[pmr_pkg::B_PDN]  = pdn_q;
            rd_d[pmr_pkg::B_ANRS] = anrs_q;
            rd_d[pmr_pkg::B_DUP]  = dup_rd;
            rd_d[pmr_pkg::B_COLT] = colt_q;          // reserved stay 0
         end
         pmr_pkg::IDX_BMS: rd_d = pmr_pkg::BMS_RST;
         pmr_pkg::IDX_IDH: rd_d = ID_HIGH;
         pmr_pkg::IDX_IDL: rd_d = ID_LOW;
         pmr_pkg::IDX_ANA: rd_d = ana_q;
         pmr_pkg::IDX_ANP: rd_d = anp_q;
         pmr_pkg::IDX_ANX: rd_d = anx_q;
         pmr_pkg::IDX_VC0: rd_d = vc0_q;
         pmr_pkg::IDX_VC1: rd_d = vc1_q;
         pmr_pkg::IDX_VC2: rd_d = vc2_q;
         default:          rd_d = 16'h0000;
      endcase
   end

   // -----------------------------------------------------------
   // avalon handshake: one wait cycle, then ack
   // -----------------------------------------------------------
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         bus_q   <= pmr_pkg::BUS_IDLE;
         rdata_q <= 32'h0000_0000;
         wait_q  <= 1'b1;
      end else if (CE_I) begin
         case (bus_q)
            pmr_pkg::BUS_IDLE: begin
               if (req) begin
                  bus_q   <= pmr_pkg::BUS_ACK;
                  rdata_q <= {16'h0000, rd_d};
                  wait_q  <= 1'b0;                    // ack in the next cycle
               end
            end
            pmr_pkg::BUS_ACK: begin
               bus_q  <= pmr_pkg::BUS_IDLE;
               wait_q <= 1'b1;
            end
            default: begin
               bus_q  <= pmr_pkg::BUS_IDLE;
               wait_q <= 1'b1;
            end
         endcase
      end
   end

   assign AVS_READDATA_O    = rdata_q;
   assign AVS_WAITREQUEST_O = wait_q;

   // -----------------------------------------------------------
   // soft reset sequencer
   // -----------------------------------------------------------
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         srst_q     <= 1'b0;
         srst_cnt_q <= 4'h0;
      end else if (CE_I) begin
         if (srst_q) begin
            // reads back one until the count runs out
            if (srst_cnt_q == 4'h1) begin
               srst_q <= 1'b0;
            end
            srst_cnt_q <= srst_cnt_q - 4'h1;
         end else if (fire_wr && idx == pmr_pkg::IDX_BMC && hi_en &&
                      wd[pmr_pkg::B_SRST]) begin
            srst_q     <= 1'b1;
            srst_cnt_q <= pmr_pkg::SRST_CYC;
         end
      end
   end

   // -----------------------------------------------------------
   // control register fields
   // -----------------------------------------------------------
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         loop_q <= pmr_pkg::BMC_RST[pmr_pkg::B_LOOP];
         spd_q  <= pmr_pkg::BMC_RST[pmr_pkg::B_SPD];
         anen_q <= pmr_pkg::BMC_RST[pmr_pkg::B_ANEN];
         pdn_q  <= pmr_pkg::BMC_RST[pmr_pkg::B_PDN];
         dup_q  <= pmr_pkg::BMC_RST[pmr_pkg::B_DUP];
         colt_q <= pmr_pkg::BMC_RST[pmr_pkg::B_COLT];
      end else if (CE_I) begin
         if (srst_q) begin
            // held at defaults during soft reset
            loop_q <= pmr_pkg::BMC_RST[pmr_pkg::B_LOOP];
            spd_q  <= pmr_pkg::BMC_RST[pmr_pkg::B_SPD];
            anen_q <= pmr_pkg::BMC_RST[pmr_pkg::B_ANEN];
            pdn_q  <= pmr_pkg::BMC_RST[pmr_pkg::B_PDN];
            dup_q  <= pmr_pkg::BMC_RST[pmr_pkg::B_DUP];
            colt_q <= pmr_pkg::BMC_RST[pmr_pkg::B_COLT];
         end else if (fire_wr && idx == pmr_pkg::IDX_BMC) begin
            if (hi_en) begin
               loop_q <= wd[pmr_pkg::B_LOOP];
               spd_q  <= wd[pmr_pkg::B_SPD];
               anen_q <= wd[pmr_pkg::B_ANEN];
               pdn_q  <= wd[pmr_pkg::B_PDN];
               dup_q  <= wd[pmr_pkg::B_DUP];
            end
            if (lo_en) begin
               colt_q <= wd[pmr_pkg::B_COLT];
            end
         end
      end
   end

   // -----------------------------------------------------------
   // negotiation restart, self clearing
   // -----------------------------------------------------------
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         anrs_q <= 1'b0;
      end else if (CE_I) begin
         if (srst_q) begin
            anrs_q <= 1'b0;
         end else if (fire_wr && idx == pmr_pkg::IDX_BMC && hi_en &&
                      !wd[pmr_pkg::B_ANEN]) begin
            anrs_q <= 1'b0;                           // disabled: pending restart cleared
         end else if (fire_wr && idx == pmr_pkg::IDX_BMC && hi_en &&
                      wd[pmr_pkg::B_ANRS]) begin
            anrs_q <= 1'b1;                           // new set wins
         end else if (anrs_q && AN_STAT_I.started) begin
            anrs_q <= 1'b0;                           // engine has begun
         end
         // a written zero is ignored here
      end
   end

   // -----------------------------------------------------------
   // advertisement and vendor words
   // -----------------------------------------------------------
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         ana_q <= pmr_pkg::ANA_RST;
         vc0_q <= pmr_pkg::VC0_RST;
         vc1_q <= pmr_pkg::VC1_RST;
         vc2_q <= pmr_pkg::VC2_RST;
      end else if (CE_I) begin
         if (srst_q) begin
            ana_q <= pmr_pkg::ANA_RST;
            vc0_q <= pmr_pkg::VC0_RST;
            vc1_q <= pmr_pkg::VC1_RST;
            vc2_q <= pmr_pkg::VC2_RST;
         end else if (fire_wr) begin
            case (idx)
               pmr_pkg::IDX_ANA: ana_q <= merge(ana_q, wd, lo_en, hi_en);
               pmr_pkg::IDX_VC0: vc0_q <= merge(vc0_q, wd, lo_en, hi_en);
               pmr_pkg::IDX_VC1: vc1_q <= merge(vc1_q, wd, lo_en, hi_en);
               pmr_pkg::IDX_VC2: vc2_q <= merge(vc2_q, wd, lo_en, hi_en);
               default: ;                             // unmapped: ignored
            endcase
         end
      end
   end

   // -----------------------------------------------------------
   // partner and expansion capture
   // -----------------------------------------------------------
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         anp_q <= pmr_pkg::ANP_RST;
         anx_q <= pmr_pkg::ANX_RST;
      end else if (CE_I) begin
         if (srst_q) begin
            anp_q <= pmr_pkg::ANP_RST;
            anx_q <= pmr_pkg::ANX_RST;
         end else if (AN_STAT_I.page_valid) begin
            anp_q <= AN_STAT_I.partner;
            anx_q <= AN_STAT_I.expansion;
         end
      end
   end

   // -----------------------------------------------------------
   // transceiver control and collision test
   // -----------------------------------------------------------
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         ctl_q <= '0;
         col_q <= 1'b0;
      end else if (CE_I) begin
         ctl_q.sw_reset    <= srst_q;
         ctl_q.loopback    <= loop_q;
         ctl_q.speed_100   <= spd_rd;
         ctl_q.full_duplex <= dup_rd;
         ctl_q.an_enable   <= anen_q;
         ctl_q.an_restart  <= anrs_q & anen_q;
         ctl_q.power_down  <= pdn_q;
         col_q             <= colt_q & TX_EN_I;
      end
   end

   assign PHY_CTL_O = ctl_q;
   assign COL_O     = col_q;

   // -----------------------------------------------------------
   // checks
   // -----------------------------------------------------------
   property p_bms_read;
      @(posedge REF_CLK_I) disable iff (!RESETN_I)
      (bus_q == pmr_pkg::BUS_IDLE && CE_I && AVS_READ_I && idx == pmr_pkg::IDX_BMS)
         |=> AVS_READDATA_O[15:0] == pmr_pkg::BMS_RST;
   endproperty
   a_bms_read: assert property (p_bms_read) else $error("status word wrong");

   property p_srst_ana;
      @(posedge REF_CLK_I) disable iff (!RESETN_I)
      (srst_q && CE_I) |=> ana_q == pmr_pkg::ANA_RST;
   endproperty
   a_srst_ana: assert property (p_srst_ana) else $error("adv not reset");

   property p_rsv_zero;
      @(posedge REF_CLK_I) disable iff (!RESETN_I)
      (bus_q == pmr_pkg::BUS_IDLE && CE_I && AVS_READ_I &&
       idx > pmr_pkg::IDX_ANX && idx < pmr_pkg::IDX_VC0)
         |=> AVS_READDATA_O == 32'h0000_0000;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero) else $error("reserved not zero");

   property p_srst_vc;
      @(posedge REF_CLK_I) disable iff (!RESETN_I)
      (srst_q && CE_I) |=> vc0_q == pmr_pkg::VC0_RST && vc2_q == pmr_pkg::VC2_RST;
   endproperty
   a_srst_vc: assert property (p_srst_vc) else $error("vendor not reset");

   property p_srst_len;
      @(posedge REF_CLK_I) disable iff (!RESETN_I || !CE_I)
      $rose(srst_q) |-> srst_q [*8] ##1 !srst_q;
   endproperty
   a_srst_len: assert property (p_srst_len) else $error("soft reset length");

   property p_bmc_rsv;
      @(posedge REF_CLK_I) disable iff (!RESETN_I)
      (bus_q == pmr_pkg::BUS_IDLE && CE_I && AVS_READ_I && idx == pmr_pkg::IDX_BMC)
         |=> (AVS_READDATA_O[15:0] & pmr_pkg::BMC_RSV_MASK) == 16'h0000;
   endproperty
   a_bmc_rsv: assert property (p_bmc_rsv) else $error("reserved bits set");

   property p_anrs_hold;
      @(posedge REF_CLK_I) disable iff (!RESETN_I)
      (anrs_q && CE_I && !AN_STAT_I.started && !srst_q && !fire_wr) |=> anrs_q;
   endproperty
   a_anrs_hold: assert property (p_anrs_hold) else $error("restart lost");

   property p_anrs_en;
      @(posedge REF_CLK_I) disable iff (!RESETN_I)
      anrs_q |-> anen_q;
   endproperty
   a_anrs_en: assert property (p_anrs_en) else $error("restart while off");

   property p_spd_out;
      @(posedge REF_CLK_I) disable iff (!RESETN_I)
      (CE_I && RESETN_I) |=> PHY_CTL_O.speed_100 == ($past(anen_q) ? $past(AN_STAT_I.speed_100)
                                                     : $past(spd_q));
   endproperty
   a_spd_out: assert property (p_spd_out) else $error("speed select wrong");

   property p_col;
      @(posedge REF_CLK_I) disable iff (!RESETN_I)
      (CE_I && colt_q && TX_EN_I) |=> COL_O;
   endproperty
   a_col: assert property (p_col) else $error("collision test");

   property p_ack;
      @(posedge REF_CLK_I) disable iff (!RESETN_I)
      (bus_q == pmr_pkg::BUS_IDLE && CE_I && (AVS_READ_I || AVS_WRITE_I))
         |=> !AVS_WAITREQUEST_O;
   endproperty
   a_ack: assert property (p_ack) else $error("no ack");

endmodule
`default_nettype wire

//--- design/pmr_pkg.sv
`default_nettype none
package pmr_pkg;
   // -----------------------------------------------------------
   // register indices (byte address = 4 * index)
   // -----------------------------------------------------------
   localparam logic [4:0] IDX_BMC  = 5'h00;
   localparam logic [4:0] IDX_BMS  = 5'h01;
   localparam logic [4:0] IDX_IDH  = 5'h02;
   localparam logic [4:0] IDX_IDL  = 5'h03;
   localparam logic [4:0] IDX_ANA  = 5'h04;
   localparam logic [4:0] IDX_ANP  = 5'h05;
   localparam logic [4:0] IDX_ANX  = 5'h06;
   localparam logic [4:0] IDX_VC0  = 5'h10;
   localparam logic [4:0] IDX_VC1  = 5'h11;
   localparam logic [4:0] IDX_VC2  = 5'h12;

   // -----------------------------------------------------------
   // values after reset
   // -----------------------------------------------------------
   localparam logic [15:0] BMC_RST = 16'h3100;
   localparam logic [15:0] BMS_RST = 16'h7809;
   localparam logic [15:0] ANA_RST = 16'h01e1;
   localparam logic [15:0] ANP_RST = 16'h0000;
   localparam logic [15:0] ANX_RST = 16'h0000;
   localparam logic [15:0] VC0_RST = 16'h0410;
   localparam logic [15:0] VC1_RST = 16'hf010;
   localparam logic [15:0] VC2_RST = 16'h7802;

   // -----------------------------------------------------------
   // control field positions
   // -----------------------------------------------------------
   localparam int B_SRST = 15;
   localparam int B_LOOP = 14;
   localparam int B_SPD  = 13;
   localparam int B_ANEN = 12;
   localparam int B_PDN  = 11;
   localparam int B_RSV  = 10;
   localparam int B_ANRS = 9;
   localparam int B_DUP  = 8;
   localparam int B_COLT = 7;
   localparam logic [15:0] BMC_RSV_MASK = 16'h047f;

   // -----------------------------------------------------------
   // timing: soft reset length
   // -----------------------------------------------------------
   localparam int CLK_MHZ      = 100;
   localparam int SRST_NS      = 80;
   localparam int SRST_CYC_INT = (SRST_NS * CLK_MHZ + 999) / 1000;
   localparam logic [3:0] SRST_CYC = 4'(SRST_CYC_INT);

   // -----------------------------------------------------------
   // types
   // -----------------------------------------------------------
   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ACK  = 1'b1
   } pmr_bus_e;

   // results from the negotiation engine
   typedef struct packed {
      logic        speed_100;
      logic        full_duplex;
      logic        started;
      logic        page_valid;
      logic [15:0] partner;
      logic [15:0] expansion;
   } pmr_an_s;

   // control handed to the transceiver
   typedef struct packed {
      logic sw_reset;
      logic loopback;
      logic speed_100;
      logic full_duplex;
      logic an_enable;
      logic an_restart;
      logic power_down;
   } pmr_ctl_s;
endpackage
`default_nettype wire

//--- verification/pmr_an_model.sv
`default_nettype none
// -----------------------------------------------------------
// negotiation engine stand-in, answers a restart after DELAY
// -----------------------------------------------------------
module pmr_an_model #(
   parameter int          DELAY   = 20,
   parameter logic [15:0] PARTNER = 16'h45e1
) (
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   // control from the register block
   input  wire pmr_pkg::pmr_ctl_s ctl_i,
   output var  pmr_pkg::pmr_an_s  an_o
);
   timeunit 1ns;
   timeprecision 100ps;
   int   cnt_q;
   logic prev_q;

   // restart edge starts a run; result is 10Mbps half duplex
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i || ctl_i.sw_reset) begin
         an_o        <= '0;
         an_o.speed_100   <= 1'b1;
         an_o.full_duplex <= 1'b1;
         cnt_q       <= 0;
         prev_q      <= 1'b0;
      end else begin
         prev_q           <= ctl_i.an_restart;
         an_o.started     <= 1'b0;
         an_o.page_valid  <= 1'b0;
         if (ctl_i.an_restart && !prev_q && ctl_i.an_enable && cnt_q == 0) begin
            cnt_q <= DELAY;
         end else if (cnt_q == 1) begin
            cnt_q            <= 0;
            an_o.started     <= 1'b1;
            an_o.page_valid  <= 1'b1;
            an_o.partner     <= PARTNER;
            an_o.speed_100   <= 1'b0;
            an_o.full_duplex <= 1'b0;
         end else if (cnt_q > 1) begin
            cnt_q <= cnt_q - 1;
         end
      end
   end
endmodule
`default_nettype wire

//--- verification/phy_mgmt_basic_control_regs_tb.sv
`default_nettype none
module phy_mgmt_basic_control_regs_tb;
   timeunit 1ns;
   timeprecision 100ps;
   // -----------------------------------------------------------
   // signals
   // -----------------------------------------------------------
   logic              clk, rst_n, ce, rd_en, wr_en, wait_req, tx_en, col;
   logic [6:0]        addr;
   logic [31:0]       wdata, rdata;
   logic [3:0]        be;
   pmr_pkg::pmr_an_s  an_stat;
   pmr_pkg::pmr_ctl_s ctl;
   int                n_errors, checks_done;
   logic [15:0]       q;

   // design and engine stand-in
   pmr_regs #(.ID_HIGH(16'h0a5a), .ID_LOW(16'h5a0a)) u_dut ( // arbitrary ids
      .REF_CLK_I(clk), .RESETN_I(rst_n), .CE_I(ce), .AVS_ADDRESS_I(addr),
      .AVS_READ_I(rd_en), .AVS_WRITE_I(wr_en), .AVS_WRITEDATA_I(wdata),
      .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_req),
      .AN_STAT_I(an_stat), .TX_EN_I(tx_en), .COL_O(col), .PHY_CTL_O(ctl));
   pmr_an_model #(.DELAY(20), .PARTNER(16'h45e1)) u_an (
      .clk_i(clk), .rst_n_i(rst_n), .ctl_i(ctl), .an_o(an_stat));

   // -----------------------------------------------------------
   // helpers
   // -----------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one avalon access, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [4:0] idx, input logic [15:0] d,
                      input logic [3:0] b, output logic [15:0] r);
      int n;
      n = 0;
      addr  <= {idx, 2'b00};
      wdata <= {16'h0000, d};
      be    <= b;
      wr_en <= w;
      rd_en <= ~w;
      do begin
         @(posedge clk);
         n++;
      end while (wait_req !== 1'b0 && n < 40);
      chk("ack wait", 16'h0002, n[15:0]);
      chk("rdata high", 16'h0000, rdata[31:16]);
      r = rdata[15:0];
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [4:0] idx, input logic [15:0] d);
      bus(1'b1, idx, d, 4'h3, q);
   endtask

   task automatic rdc(input logic [4:0] idx, input logic [15:0] e);
      bus(1'b0, idx, 16'h0000, 4'h3, q);
      chk($sformatf("reg%0h", idx), e, q);
   endtask

   function automatic logic [15:0] rst_val(input int i);
      case (i)
         0: return 16'h3100;
         1: return 16'h7809;
         2: return 16'h0a5a;
         3: return 16'h5a0a;
         4: return 16'h01e1;
         16: return 16'h0410;
         17: return 16'hf010;
         18: return 16'h7802;
         default: return 16'h0000;
      endcase
   endfunction

   // -----------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------
   // indices 0 to 18 after reset, reserved ones read as zero
   task automatic t_reset_vals;
      for (int i = 0; i < 19; i++) begin
         rdc(i[4:0], rst_val(i));
      end
   endtask

   // restart, a written zero mid-run, then negotiated result
   task automatic t_restart;
      wr(5'h00, 16'h1200);
      rdc(5'h00, 16'h3300);
      wr(5'h00, 16'h1000);
      rdc(5'h00, 16'h3300);
      chk("restart", 16'h0001, {15'h0000, ctl.an_restart});
      repeat (30) @(posedge clk);
      rdc(5'h00, 16'h1000);
      rdc(5'h05, 16'h45e1);
   endtask

   // forced speed and duplex, reserved bits written as zero
   task automatic t_forced;
      wr(5'h00, 16'h0000);
      rdc(5'h00, 16'h0000);
      wr(5'h00, 16'h2080);
      rdc(5'h00, 16'h2080);
      chk("ctl", 16'h0010, {9'h000, ctl});
      wr(5'h00, 16'h0200);
      rdc(5'h00, 16'h0000);
      chk("ctl", 16'h0000, {9'h000, ctl});
   endtask

   // collision follows transmit enable only while testing
   task automatic t_col;
      wr(5'h00, 16'h0080);
      tx_en <= 1'b1;
      repeat (2) @(posedge clk);
      chk("col", 16'h0001, {15'h0000, col});
      tx_en <= 1'b0;
      repeat (2) @(posedge clk);
      chk("col", 16'h0000, {15'h0000, col});
      // clock enable low freezes the collision flop
      ce    <= 1'b0;
      tx_en <= 1'b1;
      repeat (3) @(posedge clk);
      chk("col frozen", 16'h0000, {15'h0000, col});
      ce <= 1'b1;
      repeat (2) @(posedge clk);
      chk("col", 16'h0001, {15'h0000, col});
      wr(5'h00, 16'h0000);
      tx_en <= 1'b1;
      repeat (3) @(posedge clk);
      chk("col", 16'h0000, {15'h0000, col});
      tx_en <= 1'b0;
   endtask

   // loopback and power down reach the transceiver
   task automatic t_loop_pdn;
      wr(5'h00, 16'h4800);
      rdc(5'h00, 16'h4800);
      chk("ctl", 16'h0021, {9'h000, ctl});
      wr(5'h00, 16'h0000);
      rdc(5'h00, 16'h0000);
   endtask

   // vendor words honour byte lanes
   task automatic t_vendor;
      bus(1'b1, 5'h10, 16'habcd, 4'h1, q);
      rdc(5'h10, 16'h04cd);
      bus(1'b1, 5'h11, 16'h12ff, 4'h2, q);
      rdc(5'h11, 16'h1210);
   endtask

   // soft reset reads one, then control, advertisement, partner and first vendor word are back at defaults
   task automatic t_softrst;
      wr(5'h04, 16'h0021);
      wr(5'h00, 16'h8000);
      bus(1'b0, 5'h00, 16'h0000, 4'h3, q);
      chk("srst", 16'h8000, q & 16'h8000);
      chk("ctl reset", 16'h0001, {15'h0000, ctl.sw_reset});
      repeat (12) @(posedge clk);
      rdc(5'h00, 16'h3100);
      rdc(5'h04, 16'h01e1);
      rdc(5'h10, 16'h0410);
      rdc(5'h05, 16'h0000);
      chk("ctl", 16'h001c, {9'h000, ctl});
   endtask

   // -----------------------------------------------------------
   // run control
   // -----------------------------------------------------------
   task automatic results;
      if (n_errors == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // watchdog
   initial begin
      repeat (5000) @(posedge clk);
      n_errors++;
      results();
   end

   // main sequence
   initial begin
      n_errors = 0;
      checks_done = 0;
      rst_n = 1'b0;
      ce = 1'b1;
      rd_en = 1'b0;
      wr_en = 1'b0;
      addr = '0;
      wdata = '0;
      be = 4'h3;
      tx_en = 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset_vals();
      t_restart();
      t_forced();
      t_col();
      t_loop_pdn();
      t_vendor();
      t_softrst();
      results();
   end
endmodule
`default_nettype wire
